// *** design/sad_decoder.sv ***
// System address decoder: one-hot target selects from a 16-bit address,
// plus the illegal-address reset request.
// Assumes the core holds address and strobe stable for the cycle.
//
// Behaviour
// - A 16-bit address over 64 Kbytes yields exactly one select or none.
// - Unimplemented locations flag o_unimpl, and raise illegal-address reset only when enabled.
// - $0000-$003F selects the 64-byte primary I/O page.
// - $0040-$004F selects the 16-byte second I/O page.
// - $0500-$057F selects the 128-byte CAN buffer window.
// - $0600-$07FF selects EEPROM array B; $0800-$09FF selects array A.
// - Flash B at $0450-$04FF, $0580-$05FF, $0E00-$7FFF; flash A $8000-$FDFF.
// - $FE20-$FEFF selects the 224-byte monitor ROM.
// - $FFCC-$FFFF selects the 52-byte vector table.
// - $FE00 selects the break status register.
// - $FE01 selects reset cause; $FE03 selects break flag control.
// - $FE0B selects flash control A; $FE11 selects flash control B.
// - $FE0C selects break address high; $FE0D break address low.
// - $FE0E selects the break status and control register.
// - $FE0F selects the low-voltage status register.
// - $FE18 selects EEPROM nonvolatile B; $FE1C nonvolatile A.
// - $FE19 selects EEPROM control B; $FE1D control A.
// - $FE1B selects EEPROM array config B; $FE1F array config A.
// - $FF80 selects flash protect A; $FF81 flash protect B.

`timescale 1ns/10ps
`default_nettype none

module sad_decoder (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst,
    input  wire logic [15:0]               i_addr,
    input  wire logic                      i_access,
    input  wire logic                      i_illegal_rst_en,
    output logic      [sad_pkg::SEL_W-1:0] o_sel,
    output logic                           o_unimpl,
    output logic                           o_illegal_rst
);

    // ----------------------------------------
    // Region and register hits
    // ----------------------------------------
    logic [sad_pkg::SEL_W-1:0] hit;
    logic                      unimpl_hit;
    logic                      illegal_q;

    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        hit = sad_pkg::SEL_RST;
        hit[sad_pkg::SEL_IO_A]  = in_rng(i_addr, sad_pkg::IO_A_LO, sad_pkg::IO_A_HI);
        hit[sad_pkg::SEL_IO_B]  = in_rng(i_addr, sad_pkg::IO_B_LO, sad_pkg::IO_B_HI);
        hit[sad_pkg::SEL_RAM_A] = in_rng(i_addr, sad_pkg::RAM_A_LO, sad_pkg::RAM_A_HI);
        hit[sad_pkg::SEL_RAM_B] = in_rng(i_addr, sad_pkg::RAM_B_LO, sad_pkg::RAM_B_HI);
        hit[sad_pkg::SEL_CAN]   = in_rng(i_addr, sad_pkg::CAN_LO, sad_pkg::CAN_HI);
        hit[sad_pkg::SEL_EE_B]  = in_rng(i_addr, sad_pkg::EE_B_LO, sad_pkg::EE_B_HI);
        hit[sad_pkg::SEL_EE_A]  = in_rng(i_addr, sad_pkg::EE_A_LO, sad_pkg::EE_A_HI);
        hit[sad_pkg::SEL_FL_B]  = in_rng(i_addr, sad_pkg::FLB_W0_LO, sad_pkg::FLB_W0_HI)
                                | in_rng(i_addr, sad_pkg::FLB_W1_LO, sad_pkg::FLB_W1_HI)
                                | in_rng(i_addr, sad_pkg::FLB_W2_LO, sad_pkg::FLB_W2_HI);
        hit[sad_pkg::SEL_FL_A]  = in_rng(i_addr, sad_pkg::FLA_LO, sad_pkg::FLA_HI);
        hit[sad_pkg::SEL_MON]   = in_rng(i_addr, sad_pkg::MON_LO, sad_pkg::MON_HI);
        hit[sad_pkg::SEL_VEC]   = in_rng(i_addr, sad_pkg::VEC_LO, sad_pkg::VEC_HI);
        hit[sad_pkg::SEL_BRK_STAT]  = (i_addr == sad_pkg::BREAK_STATUS_REG);
        hit[sad_pkg::SEL_RST_CAUSE] = (i_addr == sad_pkg::RESET_CAUSE_REG);
        hit[sad_pkg::SEL_BRK_FLAG]  = (i_addr == sad_pkg::BREAK_FLAG_CTRL_REG);
        hit[sad_pkg::SEL_CFG_B]     = (i_addr == sad_pkg::CFG_ONCE_B);
        hit[sad_pkg::SEL_FLC_A]     = (i_addr == sad_pkg::FLASH_CTRL_A);
        hit[sad_pkg::SEL_FLC_B]     = (i_addr == sad_pkg::FLASH_CTRL_B);
        hit[sad_pkg::SEL_BRK_HI]    = (i_addr == sad_pkg::BREAK_ADDR_HIGH);
        hit[sad_pkg::SEL_BRK_LO]    = (i_addr == sad_pkg::BREAK_ADDR_LOW);
        hit[sad_pkg::SEL_BRK_SC]    = (i_addr == sad_pkg::BREAK_STAT_CTRL_REG);
        hit[sad_pkg::SEL_LV_STAT]   = (i_addr == sad_pkg::LOW_VOLTAGE_STATUS_REG);
        hit[sad_pkg::SEL_EENV_B]    = (i_addr == sad_pkg::EEPROM_NV_B);
        hit[sad_pkg::SEL_EENV_A]    = (i_addr == sad_pkg::EEPROM_NV_A);
        hit[sad_pkg::SEL_EEC_B]     = (i_addr == sad_pkg::EEPROM_CTRL_B);
        hit[sad_pkg::SEL_EEC_A]     = (i_addr == sad_pkg::EEPROM_CTRL_A);
        hit[sad_pkg::SEL_EEAC_B]    = (i_addr == sad_pkg::EEPROM_ARRAY_CFG_B);
        hit[sad_pkg::SEL_EEAC_A]    = (i_addr == sad_pkg::EEPROM_ARRAY_CFG_A);
        hit[sad_pkg::SEL_FLP_A]     = (i_addr == sad_pkg::FLASH_PROTECT_A);
        hit[sad_pkg::SEL_FLP_B]     = (i_addr == sad_pkg::FLASH_PROTECT_B);
    end

    // Unimplemented holes raise o_unimpl and, when enabled, the registered reset request
    assign unimpl_hit = (i_addr == sad_pkg::UNIMP_ONE)
                      | in_rng(i_addr, sad_pkg::UNIMP_MID_LO, sad_pkg::UNIMP_MID_HI)
                      | in_rng(i_addr, sad_pkg::UNIMP_HI_LO, sad_pkg::UNIMP_HI_HI);

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Selects are combinational so targets see them in the access cycle,
    // which departs from registering every output.
    assign o_sel    = i_access ? hit : sad_pkg::SEL_RST;
    assign o_unimpl = i_access & unimpl_hit;

    // Reset request is registered: high from the edge after the access for as many cycles as the access is held
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= i_access & unimpl_hit & i_illegal_rst_en;
        end
    end
    assign o_illegal_rst = illegal_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_sel_onehot: assert property (@(posedge i_sys_clk) disable iff (i_rst) $onehot0(o_sel))
        else $error("more than one target selected");
    a_unimpl_nosel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_unimpl |-> (o_sel == sad_pkg::SEL_RST))
        else $error("unimplemented access also selected a target");
    a_illegal_rst: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_unimpl && i_illegal_rst_en) |=> o_illegal_rst)
        else $error("illegal access did not raise reset");
    a_illegal_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !(o_unimpl && i_illegal_rst_en) |=> !o_illegal_rst)
        else $error("spurious illegal reset");
    a_io_page: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_access && i_addr[15:6] == 10'h000) |-> o_sel[sad_pkg::SEL_IO_A])
        else $error("io page not selected");
    a_flash_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_access && i_addr[15] && i_addr[15:9] != 7'h7f) |-> o_sel[sad_pkg::SEL_FL_A])
        else $error("flash a not selected");
    a_vec_tbl: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_access && i_addr >= sad_pkg::VEC_LO) |-> o_sel[sad_pkg::SEL_VEC])
        else $error("vector table not selected");
    a_mon_rom: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_access && i_addr[15:8] == 8'hfe && i_addr[7:5] != 3'h0) |-> o_sel[sad_pkg::SEL_MON])
        else $error("monitor rom not selected");
    a_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_access |-> (o_sel == sad_pkg::SEL_RST && !o_unimpl))
        else $error("select without access");
    a_unimpl_page: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_access && i_addr[15:7] == 9'h1fe) |-> o_unimpl)
        else $error("unimplemented page not flagged");
    a_eeprom_b: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_access && i_addr[15:9] == 7'h03) |-> o_sel[sad_pkg::SEL_EE_B])
        else $error("eeprom b not selected");
    a_can_window: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_access && i_addr[15:7] == 9'h00a) |-> o_sel[sad_pkg::SEL_CAN])
        else $error("can window not selected");

    c_ram_b: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_sel[sad_pkg::SEL_RAM_B]);
    c_can:   cover property (@(posedge i_sys_clk) disable iff (i_rst) o_sel[sad_pkg::SEL_CAN]);
    c_rst:   cover property (@(posedge i_sys_clk) disable iff (i_rst) o_illegal_rst);
    c_none:  cover property (@(posedge i_sys_clk) disable iff (i_rst)
        i_access && o_sel == sad_pkg::SEL_RST && !o_unimpl);

endmodule

`default_nettype wire

// *** design/sad_pkg.sv ***
// Constants for the system address decoder: region bounds, target codes,
// and the widths shared by the decoder and its assertions.
// Assumes a 16-bit processor address and one bus clock.

package sad_pkg;

    // ----------------------------------------
    // Address space
    // ----------------------------------------
    localparam int ADDR_W = 16;

    // ----------------------------------------
    // Region bounds
    // ----------------------------------------
    localparam logic [15:0] IO_A_LO     = 16'h0000;
    localparam logic [15:0] IO_A_HI     = 16'h003f;
    localparam logic [15:0] IO_B_LO     = 16'h0040;
    localparam logic [15:0] IO_B_HI     = 16'h004f;
    localparam logic [15:0] RAM_A_LO    = 16'h0050;
    localparam logic [15:0] RAM_A_HI    = 16'h044f;
    localparam logic [15:0] FLB_W0_LO   = 16'h0450;
    localparam logic [15:0] FLB_W0_HI   = 16'h04ff;
    localparam logic [15:0] CAN_LO      = 16'h0500;
    localparam logic [15:0] CAN_HI      = 16'h057f;
    localparam logic [15:0] FLB_W1_LO   = 16'h0580;
    localparam logic [15:0] FLB_W1_HI   = 16'h05ff;
    localparam logic [15:0] EE_B_LO     = 16'h0600;
    localparam logic [15:0] EE_B_HI     = 16'h07ff;
    localparam logic [15:0] EE_A_LO     = 16'h0800;
    localparam logic [15:0] EE_A_HI     = 16'h09ff;
    localparam logic [15:0] RAM_B_LO    = 16'h0a00;
    localparam logic [15:0] RAM_B_HI    = 16'h0dff;
    localparam logic [15:0] FLB_W2_LO   = 16'h0e00;
    localparam logic [15:0] FLB_W2_HI   = 16'h7fff;
    localparam logic [15:0] FLA_LO      = 16'h8000;
    localparam logic [15:0] FLA_HI      = 16'hfdff;
    localparam logic [15:0] MON_LO      = 16'hfe20;
    localparam logic [15:0] MON_HI      = 16'hfeff;
    localparam logic [15:0] UNIMP_HI_LO = 16'hff00;
    localparam logic [15:0] UNIMP_HI_HI = 16'hff7f;
    localparam logic [15:0] UNIMP_MID_LO = 16'hfe12;
    localparam logic [15:0] UNIMP_MID_HI = 16'hfe17;
    localparam logic [15:0] UNIMP_ONE   = 16'hfe06;
    localparam logic [15:0] VEC_LO      = 16'hffcc;
    localparam logic [15:0] VEC_HI      = 16'hffff;

    // ----------------------------------------
    // Single-byte system registers
    // ----------------------------------------
    localparam logic [15:0] BREAK_STATUS_REG       = 16'hfe00;
    localparam logic [15:0] RESET_CAUSE_REG        = 16'hfe01;
    localparam logic [15:0] BREAK_FLAG_CTRL_REG    = 16'hfe03;
    localparam logic [15:0] CFG_ONCE_B             = 16'hfe09;
    localparam logic [15:0] FLASH_CTRL_A           = 16'hfe0b;
    localparam logic [15:0] BREAK_ADDR_HIGH        = 16'hfe0c;
    localparam logic [15:0] BREAK_ADDR_LOW         = 16'hfe0d;
    localparam logic [15:0] BREAK_STAT_CTRL_REG    = 16'hfe0e;
    localparam logic [15:0] LOW_VOLTAGE_STATUS_REG = 16'hfe0f;
    localparam logic [15:0] FLASH_CTRL_B           = 16'hfe11;
    localparam logic [15:0] EEPROM_NV_B            = 16'hfe18;
    localparam logic [15:0] EEPROM_CTRL_B          = 16'hfe19;
    localparam logic [15:0] EEPROM_ARRAY_CFG_B     = 16'hfe1b;
    localparam logic [15:0] EEPROM_NV_A            = 16'hfe1c;
    localparam logic [15:0] EEPROM_CTRL_A          = 16'hfe1d;
    localparam logic [15:0] EEPROM_ARRAY_CFG_A     = 16'hfe1f;
    localparam logic [15:0] FLASH_PROTECT_A        = 16'hff80;
    localparam logic [15:0] FLASH_PROTECT_B        = 16'hff81;

    // ----------------------------------------
    // Target select bit positions (one-hot vector)
    // ----------------------------------------
    localparam int SEL_IO_A      = 0;
    localparam int SEL_IO_B      = 1;
    localparam int SEL_RAM_A     = 2;
    localparam int SEL_RAM_B     = 3;
    localparam int SEL_CAN       = 4;
    localparam int SEL_EE_A      = 5;
    localparam int SEL_EE_B      = 6;
    localparam int SEL_FL_A      = 7;
    localparam int SEL_FL_B      = 8;
    localparam int SEL_MON       = 9;
    localparam int SEL_VEC       = 10;
    localparam int SEL_BRK_STAT  = 11;
    localparam int SEL_RST_CAUSE = 12;
    localparam int SEL_BRK_FLAG  = 13;
    localparam int SEL_CFG_B     = 14;
    localparam int SEL_FLC_A     = 15;
    localparam int SEL_FLC_B     = 16;
    localparam int SEL_BRK_HI    = 17;
    localparam int SEL_BRK_LO    = 18;
    localparam int SEL_BRK_SC    = 19;
    localparam int SEL_LV_STAT   = 20;
    localparam int SEL_EENV_B    = 21;
    localparam int SEL_EENV_A    = 22;
    localparam int SEL_EEC_B     = 23;
    localparam int SEL_EEC_A     = 24;
    localparam int SEL_EEAC_B    = 25;
    localparam int SEL_EEAC_A    = 26;
    localparam int SEL_FLP_A     = 27;
    localparam int SEL_FLP_B     = 28;
    localparam int SEL_W         = 29;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [SEL_W-1:0] SEL_RST = 29'h0000000;

endpackage

// *** verification/sad_core_model.sv ***
// Model of the processor core that issues bus addresses to the decoder.
// Assumes the bench calls its tasks just after a falling clock edge.

`timescale 1ns/10ps
`default_nettype none

module sad_core_model (
    input  wire logic        i_sys_clk,
    output logic      [15:0] o_addr,
    output logic             o_access
);
    // ----------------------------------------
    // Bus drive
    // ----------------------------------------
    initial begin
        o_addr   = 16'h0000;
        o_access = 1'b0;
    end

    // Unimplemented places are issued by the refusal, held-access and mid-reset checks
    task automatic put(input logic [15:0] a);
        o_addr   = a;
        o_access = 1'b1;
    endtask

    // Released address flips so a stale value can never pass for a decode
    task automatic idle();
        o_access = 1'b0;
        o_addr   = ~o_addr;
    endtask
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the address decoder.
// Assumes sad_pkg is compiled first; the core model drives the address bus.

`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic                      i_sys_clk = 1'b0;
    logic                      i_rst     = 1'b1;
    logic                      rst_en    = 1'b0;
    logic [15:0]               addr;
    logic                      access;
    logic [sad_pkg::SEL_W-1:0] o_sel;
    logic                      o_unimpl;
    logic                      o_illegal_rst;
    int                        n_mismatch = 0;
    int                        cmp_count  = 0;

    always #2.5 i_sys_clk = ~i_sys_clk;

    sad_core_model sad_core_model_inst (.i_sys_clk(i_sys_clk), .o_addr(addr), .o_access(access));
    sad_decoder sad_decoder_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(addr), .i_access(access),
        .i_illegal_rst_en(rst_en), .o_sel(o_sel), .o_unimpl(o_unimpl), .o_illegal_rst(o_illegal_rst));

    // ----------------------------------------
    // Compare and drive helpers
    // ----------------------------------------
    task automatic cmp_sel(input logic [sad_pkg::SEL_W-1:0] got, input logic [sad_pkg::SEL_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: select %h, expected %h at address %h", $time, got, exp, addr);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: %s is %b, expected %b", $time, what, got, exp);
        end
    endtask

    task automatic probe(input logic [15:0] a, input int b, input logic un, input logic rq);
        logic [sad_pkg::SEL_W-1:0] e;
        e = '0;
        if (b >= 0) e[b] = 1'b1;
        @(negedge i_sys_clk);
        sad_core_model_inst.put(a);
        #1;
        cmp_sel(o_sel, e);
        cmp_bit(o_unimpl, un, "unimplemented flag");
        @(negedge i_sys_clk);
        sad_core_model_inst.idle();
        cmp_bit(o_illegal_rst, rq, "reset request");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_regions();
        logic [15:0] lo [13] = '{16'h0000, 16'h0040, 16'h0050, 16'h0a00, 16'h0500, 16'h0800, 16'h0600,
                                 16'h8000, 16'h0450, 16'h0580, 16'h0e00, 16'hfe20, 16'hffcc};
        logic [15:0] hi [13] = '{16'h003f, 16'h004f, 16'h044f, 16'h0dff, 16'h057f, 16'h09ff, 16'h07ff,
                                 16'hfdff, 16'h04ff, 16'h05ff, 16'h7fff, 16'hfeff, 16'hffff};
        int b;
        rst_en = 1'b1;
        for (int i = 0; i < 13; i++) begin
            b = (i < 9) ? i : ((i < 11) ? 8 : i - 2);
            probe(lo[i], sad_pkg::SEL_IO_A + b, 1'b0, 1'b0);
            probe(hi[i], sad_pkg::SEL_IO_A + b, 1'b0, 1'b0);
        end
        $display("test_regions done");
    endtask

    task automatic test_sysregs();
        logic [15:0] ra [18] = '{16'hfe00, 16'hfe01, 16'hfe03, 16'hfe09, 16'hfe0b, 16'hfe11, 16'hfe0c,
            16'hfe0d, 16'hfe0e, 16'hfe0f, 16'hfe18, 16'hfe1c, 16'hfe19, 16'hfe1d, 16'hfe1b, 16'hfe1f,
            16'hff80, 16'hff81};
        for (int i = 0; i < 18; i++) begin
            probe(ra[i], sad_pkg::SEL_BRK_STAT + i, 1'b0, 1'b0);
        end
        $display("test_sysregs done");
    endtask

    task automatic test_refusals();
        logic [15:0] rs [11] = '{16'hfe02, 16'hfe04, 16'hfe05, 16'hfe07, 16'hfe08, 16'hfe0a, 16'hfe10,
                                 16'hfe1a, 16'hfe1e, 16'hff82, 16'hffcb};
        logic [15:0] un [5]  = '{16'hfe06, 16'hfe12, 16'hfe17, 16'hff00, 16'hff7f};
        rst_en = 1'b1;
        foreach (rs[i]) probe(rs[i], -1, 1'b0, 1'b0);
        foreach (un[i]) probe(un[i], -1, 1'b1, 1'b1);
        @(negedge i_sys_clk) rst_en = 1'b0;
        foreach (un[i]) probe(un[i], -1, 1'b1, 1'b0);
        $display("test_refusals done");
    endtask

    // Held offending access keeps the request high every cycle; a good access right after ends it
    task automatic test_held();
        @(negedge i_sys_clk);
        rst_en = 1'b1;
        sad_core_model_inst.put(16'hff10);
        repeat (3) @(negedge i_sys_clk) cmp_bit(o_illegal_rst, 1'b1, "held reset request");
        sad_core_model_inst.put(16'h0a00);
        #1 cmp_sel(o_sel, 29'h1 << sad_pkg::SEL_RAM_B);
        @(negedge i_sys_clk) cmp_bit(o_illegal_rst, 1'b0, "good access ends request");
        sad_core_model_inst.idle();
        @(negedge i_sys_clk) cmp_bit(o_illegal_rst, 1'b0, "after good access");
        $display("test_held done");
    endtask

    // Reset in mid-run must silence the request even while the bad access stands
    task automatic test_midreset();
        @(negedge i_sys_clk);
        sad_core_model_inst.put(16'hff00);
        i_rst = 1'b1;
        repeat (2) @(negedge i_sys_clk) cmp_bit(o_illegal_rst, 1'b0, "request in reset");
        cmp_bit(o_unimpl, 1'b1, "flag in reset");
        i_rst = 1'b0;
        @(negedge i_sys_clk) cmp_bit(o_illegal_rst, 1'b1, "request after reset");
        sad_core_model_inst.idle();
        $display("test_midreset done");
    endtask

    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge i_sys_clk);
        @(negedge i_sys_clk) i_rst = 1'b0;
        test_regions();
        test_sysregs();
        test_refusals();
        test_held();
        test_midreset();
        stop_test();
    end

    // Whole run is near 145 cycles; eleven times that leaves ample room
    initial begin
        #8000;
        n_mismatch++;
        $display("Error %0t: watchdog expired", $time);
        stop_test();
    end
endmodule

`default_nettype wire
